//--- common/pll_cfg_pkg.sv
// Package: register map, field layout, reset values and rates of the PLL block
package pll_cfg_pkg;

    // ************************************************************
    // Register indices and byte addresses (byte address = 4 * index)
    // ************************************************************
    localparam logic [11:0] IDX_MULT    = 12'h034;
    localparam logic [11:0] IDX_REFERENCE_DIVIDER_FIELD  = 12'h035;
    localparam logic [11:0] IDX_POST_DIVIDER_FIELD = 12'h036;
    localparam logic [11:0] IDX_FLAGS   = 12'h037;
    localparam logic [11:0] IDX_CLKSEL  = 12'h039;
    localparam logic [11:0] IDX_OSC     = 12'h2FA;
    localparam logic [11:0] IDX_WRITE_PROTECT_BIT    = 12'h2FB;
    localparam int          ADDR_W      = 12;

    // ************************************************************
    // Field layout and writable masks
    // ************************************************************
    localparam logic [7:0] MASK_REFERENCE_DIVIDER_FIELD  = 8'hCF;
    localparam logic [7:0] MASK_POST_DIVIDER_FIELD = 8'h1F;
    localparam logic [7:0] MASK_FLAGS   = 8'h76;
    localparam logic [7:0] MASK_BIT7    = 8'h80;
    localparam logic [7:0] MASK_BIT0    = 8'h01;
    localparam int BIT_POWER_ON_RESET_FLAG   = 6;
    localparam int BIT_LOW_VOLTAGE_RESET_FLAG   = 5;
    localparam int BIT_LOCK_CHANGE_FLAG = 4;
    localparam int BIT_LOCK   = 3;
    localparam int BIT_ILLEGAL_ADDRESS_RESET_FLAG   = 2;
    localparam int BIT_OSC_CHANGE_FLAG  = 1;
    localparam int BIT_OSC_QUALIFIED_STATUS  = 0;

    // ************************************************************
    // Values after reset
    // ************************************************************
    localparam logic [7:0] RST_MULT    = 8'h00;
    localparam logic [7:0] RST_REFERENCE_DIVIDER_FIELD  = 8'h00;
    localparam logic [7:0] RST_POST_DIVIDER_FIELD = 8'h03;
    localparam logic [7:0] RST_CLKSEL  = 8'h00;
    localparam logic [7:0] RST_OSC     = 8'h00;
    localparam logic [7:0] RST_WRITE_PROTECT_BIT    = 8'h00;

    // ************************************************************
    // Rates, all frequencies carried in kHz
    // ************************************************************
    localparam int CLK_PERIOD_NS = 20;
    localparam int SYS_KHZ       = 1000000 / CLK_PERIOD_NS;
    localparam int IRC_KHZ       = 1000;
    localparam int FREQ_W        = 24;
    localparam logic [1:0] FILTER_FIXED = 2'h0;

endpackage

//--- logic/rate_tick_gen.sv
// Fractional divider: one-cycle enable pulses at a rate given in kHz
module rate_tick_gen #(
    parameter int W = 24
) (
    input  wire logic         sys_clk,   // System clock
    input  wire logic         rst_n,     // Asynchronous reset, active low
    input  wire logic [W-1:0] rate_khz,  // Wanted pulse rate in kHz
    output logic              tick       // One-cycle enable pulse
);

    typedef struct packed {
        logic [W:0] acc;
        logic       tick;
    } tick_state_type;

    localparam logic [W:0] SYS = (W + 1)'(pll_cfg_pkg::SYS_KHZ);

    tick_state_type s;
    tick_state_type next_s;
    logic [W:0]     sum;

    // ************************************************************
    // Phase accumulator
    // ************************************************************
    // Rates above the system clock cannot be shown; they saturate
    always_comb begin
        next_s = s;
        sum = s.acc + {1'b0, rate_khz};
        if (sum >= SYS) begin
            next_s.acc  = sum - SYS;
            next_s.tick = 1'b1;
        end else begin
            next_s.acc  = sum;
            next_s.tick = 1'b0;
        end
    end

    // State register
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign tick = s.tick;

endmodule

//--- logic/pll_synth_config_regs.sv
// PLL configuration registers, reset-cause flags and clock rate model
// Notes on behaviour
// - Divider writes need protect off, PLL selected
// - Accepted divider write clears lock, oscillator status
// - VCO equals two times reference times multiplier+1
// - Reference is oscillator/(divider+1), else 1 MHz RC
// - RC reference keeps filter fixed at lowest range
// - Post divider writes need PLL selected
// - Output is VCO/(post+1) locked, VCO/4 unlocked
// - Bus clock is half PLL output when selected
// - Power-on reset sets its flag; system reset keeps
// - Low-voltage flag set by LVR or power-on
// - Illegal-address flag set; power-on clears it
// - Flags clear by writing one; power-on clears lock, osc and illegal flags
// - Status changes set lock and oscillator change flags
module pll_synth_config_regs #(
    parameter int OSC_KHZ = 8000
) (
    input  wire logic        sys_clk,         // System clock, 50 MHz
    input  wire logic        rst_n,           // System reset, active low
    input  wire logic        psel,            // APB select
    input  wire logic        penable,         // APB enable
    input  wire logic        pwrite,          // APB direction
    input  wire logic [11:0] paddr,           // APB byte address
    input  wire logic [31:0] pwdata,          // APB write data
    output logic      [31:0] prdata,          // APB read data
    output logic             pready,          // APB ready
    output logic             pslverr,         // APB error, unmapped
    input  wire logic        por_event,       // Power-on reset pulse
    input  wire logic        lvr_event,       // Low-voltage reset pulse
    input  wire logic        illegal_addr_event, // Illegal address reset
    input  wire logic        lock_detect,     // Analog lock detector
    input  wire logic        osc_detect,      // Oscillator qualifier
    output logic      [23:0] reference_clock, // Reference rate, kHz
    output logic      [23:0] vco_clock,       // VCO rate, kHz
    output logic      [23:0] pll_output_clock, // PLL output rate, kHz
    output logic      [23:0] bus_clock,       // Bus rate, kHz
    output logic             bus_clock_tick,  // Bus rate enable pulse
    output logic      [1:0]  vco_gain_range,  // VCO gain to analog
    output logic      [1:0]  loop_filter_range, // Filter range to analog
    output logic             pll_clock_select // PLL drives system clock
);

    localparam int FW = pll_cfg_pkg::FREQ_W;

    typedef struct packed {
        logic [7:0]    mult;
        logic [7:0]    reference_divider_field;
        logic [7:0]    post_divider_field;
        logic [7:0]    clksel;
        logic [7:0]    osc;
        logic [7:0]    write_protect_bit;
        logic          lock;
        logic          osc_qualified_status;
        logic [31:0]   prdata;
        logic          pready;
        logic          pslverr;
        logic [FW-1:0] ref_khz;
        logic [FW-1:0] vco_khz;
        logic [FW-1:0] pll_khz;
        logic [FW-1:0] bus_khz;
        logic [1:0]    filter;
    } cfg_state_type;

    // Reset-cause flags live apart: they must outlast a system reset
    typedef struct packed {
        logic power_on_reset_flag;
        logic low_voltage_reset_flag;
        logic lock_change_flag;
        logic illegal_address_reset_flag;
        logic osc_change_flag;
    } flag_state_type;

    cfg_state_type  s;
    cfg_state_type  next_s;
    flag_state_type f;
    flag_state_type next_f;
    logic [6:0]     sel;
    logic           wr;
    logic           div_ok;
    logic [7:0]     wbyte;
    logic [7:0]     rd;
    logic [7:0]     fbyte;

    // ************************************************************
    // Address decode
    // ************************************************************
    // One-hot select; bit order mult, reference_divider_field, post, flags, clk, osc, write_protect_bit
    function automatic logic [6:0] decode(input logic [11:0] a);
        logic [6:0] d;
        d = 7'h00;
        if (a[1:0] == 2'h0) begin
            case (a[11:2])
                pll_cfg_pkg::IDX_MULT[9:0]:    d = 7'h01;
                pll_cfg_pkg::IDX_REFERENCE_DIVIDER_FIELD[9:0]:  d = 7'h02;
                pll_cfg_pkg::IDX_POST_DIVIDER_FIELD[9:0]: d = 7'h04;
                pll_cfg_pkg::IDX_FLAGS[9:0]:   d = 7'h08;
                pll_cfg_pkg::IDX_CLKSEL[9:0]:  d = 7'h10;
                pll_cfg_pkg::IDX_OSC[9:0]:     d = 7'h20;
                pll_cfg_pkg::IDX_WRITE_PROTECT_BIT[9:0]:    d = 7'h40;
                default:                       d = 7'h00;
            endcase
        end
        return d;
    endfunction

    // Write strobe valid only in the access cycle that shows pready
    always_comb begin
        sel    = decode(paddr);
        wr     = psel & penable & pwrite & s.pready;
        wbyte  = pwdata[7:0];
        div_ok = ~s.write_protect_bit[0] & s.clksel[7];
        fbyte  = {1'b0, f.power_on_reset_flag, f.low_voltage_reset_flag, f.lock_change_flag, s.lock,
                  f.illegal_address_reset_flag, f.osc_change_flag, s.osc_qualified_status};
    end

    // Read multiplexer
    always_comb begin
        case (sel)
            7'h01:   rd = s.mult;
            7'h02:   rd = s.reference_divider_field;
            7'h04:   rd = s.post_divider_field;
            7'h08:   rd = fbyte;
            7'h10:   rd = s.clksel;
            7'h20:   rd = s.osc;
            7'h40:   rd = s.write_protect_bit;
            default: rd = 8'h00;
        endcase
    end

    // ************************************************************
    // Registers, status and rate model
    // ************************************************************
    always_comb begin
        next_s = s;
        // Zero-wait slave: ready in the first access cycle
        next_s.pready  = psel & ~penable;
        next_s.pslverr = psel & ~penable & (sel == 7'h00);
        if (psel & ~penable) begin
            next_s.prdata = {24'h000000, rd};
        end
        if (wr & div_ok & sel[0]) begin
            next_s.mult = wbyte;
        end
        if (wr & div_ok & sel[1]) begin
            next_s.reference_divider_field = wbyte & pll_cfg_pkg::MASK_REFERENCE_DIVIDER_FIELD;
        end
        if (wr & s.clksel[7] & sel[2]) begin
            next_s.post_divider_field = wbyte & pll_cfg_pkg::MASK_POST_DIVIDER_FIELD;
        end
        if (wr & ~s.write_protect_bit[0] & sel[4]) begin
            next_s.clksel = wbyte & pll_cfg_pkg::MASK_BIT7;
        end
        if (wr & ~s.write_protect_bit[0] & sel[5]) begin
            next_s.osc = wbyte & pll_cfg_pkg::MASK_BIT7;
        end
        if (wr & sel[6]) begin
            next_s.write_protect_bit = wbyte & pll_cfg_pkg::MASK_BIT0;
        end
        // Status follows the detectors, forced low by a divider change
        if (wr & div_ok & (sel[0] | sel[1])) begin
            next_s.lock  = 1'b0;
            next_s.osc_qualified_status = 1'b0;
        end else begin
            next_s.lock  = lock_detect;
            next_s.osc_qualified_status = osc_detect & s.osc[7];
        end
        // Reference: divided crystal or the fixed RC clock
        if (s.osc[7]) begin
            next_s.ref_khz = FW'(OSC_KHZ / (s.reference_divider_field[3:0] + 1));
        end else begin
            next_s.ref_khz = FW'(pll_cfg_pkg::IRC_KHZ);
        end
        next_s.vco_khz = FW'(2 * s.ref_khz * (s.mult[5:0] + 1));
        // Unlocked output is slowed to protect the core
        if (s.lock) begin
            next_s.pll_khz = FW'(s.vco_khz / (s.post_divider_field[4:0] + 1));
        end else begin
            next_s.pll_khz = s.vco_khz >> 2;
        end
        if (s.clksel[7]) begin
            next_s.bus_khz = s.pll_khz >> 1;
        end else begin
            next_s.bus_khz = s.ref_khz >> 1;
        end
        // Range code reaches the filter only with the crystal running
        if (s.osc[7]) begin
            next_s.filter = s.reference_divider_field[7:6];
        end else begin
            next_s.filter = pll_cfg_pkg::FILTER_FIXED;
        end
    end

    // State register
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            s         <= '0;
            s.mult    <= pll_cfg_pkg::RST_MULT;
            s.reference_divider_field  <= pll_cfg_pkg::RST_REFERENCE_DIVIDER_FIELD;
            s.post_divider_field <= pll_cfg_pkg::RST_POST_DIVIDER_FIELD;
            s.clksel  <= pll_cfg_pkg::RST_CLKSEL;
            s.osc     <= pll_cfg_pkg::RST_OSC;
            s.write_protect_bit    <= pll_cfg_pkg::RST_WRITE_PROTECT_BIT;
        end else begin
            s <= next_s;
        end
    end

    // ************************************************************
    // Reset-cause and change flags
    // ************************************************************
    // A set in the same cycle as a clearing write wins
    always_comb begin
        next_f = f;
        if (wr & sel[3]) begin
            if (wbyte[pll_cfg_pkg::BIT_POWER_ON_RESET_FLAG])   next_f.power_on_reset_flag = 1'b0;
            if (wbyte[pll_cfg_pkg::BIT_LOW_VOLTAGE_RESET_FLAG])   next_f.low_voltage_reset_flag = 1'b0;
            if (wbyte[pll_cfg_pkg::BIT_LOCK_CHANGE_FLAG]) next_f.lock_change_flag = 1'b0;
            if (wbyte[pll_cfg_pkg::BIT_ILLEGAL_ADDRESS_RESET_FLAG])   next_f.illegal_address_reset_flag = 1'b0;
            if (wbyte[pll_cfg_pkg::BIT_OSC_CHANGE_FLAG])  next_f.osc_change_flag = 1'b0;
        end
        // Status is pinned low in reset; the rst_n term keeps a change from being reported then
        if (rst_n && next_s.lock != s.lock) begin
            next_f.lock_change_flag = 1'b1;
        end
        if (rst_n && next_s.osc_qualified_status != s.osc_qualified_status) begin
            next_f.osc_change_flag = 1'b1;
        end
        if (lvr_event) begin
            next_f.low_voltage_reset_flag = 1'b1;
        end
        if (illegal_addr_event) begin
            next_f.illegal_address_reset_flag = 1'b1;
        end
        if (por_event) begin
            next_f.power_on_reset_flag   = 1'b1;
            next_f.low_voltage_reset_flag   = 1'b1;
            next_f.illegal_address_reset_flag   = 1'b0;
            next_f.lock_change_flag = 1'b0;
            next_f.osc_change_flag  = 1'b0;
        end
    end

    // No reset here: only a power-on event defines these flags
    always_ff @(posedge sys_clk) begin
        f <= next_f;
    end

    // Bus-rate enable pulses
    rate_tick_gen #(
        .W (FW)
    ) u_bus_tick (
        .sys_clk  (sys_clk),
        .rst_n    (rst_n),
        .rate_khz (s.bus_khz),
        .tick     (bus_clock_tick)
    );

    // Outputs straight from the state register
    assign prdata            = s.prdata;
    assign pready            = s.pready;
    assign pslverr           = s.pslverr;
    assign reference_clock   = s.ref_khz;
    assign vco_clock         = s.vco_khz;
    assign pll_output_clock  = s.pll_khz;
    assign bus_clock         = s.bus_khz;
    assign vco_gain_range    = s.mult[7:6];
    assign loop_filter_range = s.filter;
    assign pll_clock_select  = s.clksel[7];

    // ************************************************************
    // Assertions
    // ************************************************************
    a_mult_protect: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        (wr & sel[0] & ~div_ok) |=> $stable(s.mult))
        else $error("multiplier changed while guarded");

    a_div_clears_status: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        (wr & div_ok & (sel[0] | sel[1])) |=> (!s.lock && !s.osc_qualified_status))
        else $error("status not cleared by divider write");

    a_vco_formula: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        ##1 s.vco_khz == FW'(2 * $past(s.ref_khz)
                         * ($past(s.mult[5:0]) + 1)))
        else $error("vco rate wrong");

    a_rc_reference: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        (rst_n & !s.osc[7]) |=> s.ref_khz == FW'(pll_cfg_pkg::IRC_KHZ))
        else $error("reference not the RC clock");

    a_filter_fixed: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        (!s.osc[7])[*2] |-> loop_filter_range == pll_cfg_pkg::FILTER_FIXED)
        else $error("filter moved while on RC reference");

    a_post_guard: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        (wr & sel[2] & ~s.clksel[7]) |=> $stable(s.post_divider_field))
        else $error("post divider changed without PLL select");

    a_unlocked_quarter: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        !s.lock |=> s.pll_khz == ($past(s.vco_khz) >> 2))
        else $error("unlocked output not a quarter");

    a_bus_half: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        s.clksel[7] |=> s.bus_khz == ($past(s.pll_khz) >> 1))
        else $error("bus rate not half of PLL output");

    a_por_flags: assert property (
        @(posedge sys_clk)
        por_event |=> (f.power_on_reset_flag && f.low_voltage_reset_flag && !f.illegal_address_reset_flag))
        else $error("power-on flags wrong");

    a_illegal_address_reset_flag_set: assert property (
        @(posedge sys_clk)
        (illegal_addr_event & ~por_event) |=> f.illegal_address_reset_flag)
        else $error("illegal address flag not set");

    a_flag_zero_write: assert property (
        @(posedge sys_clk)
        (wr & sel[3] & ~wbyte[pll_cfg_pkg::BIT_POWER_ON_RESET_FLAG] & ~por_event)
        |=> f.power_on_reset_flag == $past(f.power_on_reset_flag))
        else $error("zero write changed power-on flag");

    a_lock_change: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        $changed(s.lock) && !$past(por_event) |-> f.lock_change_flag)
        else $error("lock change not flagged");

endmodule

//--- bench/tb.sv
// Self-checking testbench for the PLL configuration register block
module tb;
    timeunit 1ns;
    timeprecision 1ps;

    // ************************************************************
    // Addresses, signals and the block under test
    // ************************************************************
    localparam logic [11:0] A_MULT = {pll_cfg_pkg::IDX_MULT[9:0], 2'h0};
    localparam logic [11:0] A_REF  = {pll_cfg_pkg::IDX_REFERENCE_DIVIDER_FIELD[9:0], 2'h0};
    localparam logic [11:0] A_POST = {pll_cfg_pkg::IDX_POST_DIVIDER_FIELD[9:0], 2'h0};
    localparam logic [11:0] A_FLG  = {pll_cfg_pkg::IDX_FLAGS[9:0], 2'h0};
    localparam logic [11:0] A_CLK  = {pll_cfg_pkg::IDX_CLKSEL[9:0], 2'h0};
    localparam logic [11:0] A_OSC  = {pll_cfg_pkg::IDX_OSC[9:0], 2'h0};
    localparam logic [11:0] A_WRITE_PROTECT_BIT = {pll_cfg_pkg::IDX_WRITE_PROTECT_BIT[9:0], 2'h0};

    typedef struct {
        logic [11:0] a;
        logic [7:0]  w;
        logic [7:0]  r;
        logic        e;
    } row_type;

    logic        sys_clk = 1'b0;
    logic        rst_n = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h00000000;
    logic [2:0]  ev = 3'h0;
    logic        lock_detect = 1'b0;
    logic        osc_detect = 1'b0;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic [23:0] reference_clock;
    logic [23:0] vco_clock;
    logic [23:0] pll_output_clock;
    logic [23:0] bus_clock;
    logic        bus_clock_tick;
    logic [1:0]  vco_gain_range;
    logic [1:0]  loop_filter_range;
    logic        pll_clock_select;
    int          fails = 0;
    int          total_checks = 0;
    int          cyc = 0;
    int          n;

    pll_synth_config_regs u_pll_synth_config_regs (
        .sys_clk(sys_clk), .rst_n(rst_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .por_event(ev[0]),
        .lvr_event(ev[1]), .illegal_addr_event(ev[2]),
        .lock_detect(lock_detect), .osc_detect(osc_detect),
        .reference_clock(reference_clock), .vco_clock(vco_clock),
        .pll_output_clock(pll_output_clock), .bus_clock(bus_clock),
        .bus_clock_tick(bus_clock_tick), .vco_gain_range(vco_gain_range),
        .loop_filter_range(loop_filter_range),
        .pll_clock_select(pll_clock_select)
    );

    // 50 MHz clock; cycle ceiling well above the planned run
    always #10 sys_clk = ~sys_clk;
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            fails++;
            test_done();
        end
    end

    // ************************************************************
    // Shared tasks
    // ************************************************************
    task automatic test_done;
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [23:0] x, got);
        total_checks++;
        if (got !== x) begin
            fails++;
            $display("[FAIL] %s expected %h seen %h", nm, x, got);
        end
    endtask

    // Idle edge first so psel is never assigned twice in one step;
    // pready, read data and error are taken at the rising edge only
    task automatic apb(input logic wr, input logic [11:0] a,
                       input logic [7:0] d, output logic [7:0] r,
                       output logic e);
        int k;
        @(posedge sys_clk);
        psel   <= 1'b1;
        pwrite <= wr;
        paddr  <= a;
        pwdata <= {24'h000000, d};
        @(posedge sys_clk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge sys_clk);
            k++;
        end while (pready !== 1'b1 && k < 20);
        if (pready !== 1'b1) begin
            fails++;
            $display("[FAIL] pready expected 1 seen %b", pready);
        end
        r = prdata[7:0];
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        logic [7:0] r;
        logic       e;
        apb(1'b1, a, d, r, e);
    endtask

    task automatic rd(input logic [11:0] a, input logic [7:0] x,
                      input string nm);
        logic [7:0] r;
        logic       e;
        apb(1'b0, a, 8'h00, r, e);
        chk(nm, {16'h0000, x}, {16'h0000, r});
    endtask

    task automatic pulse(input logic [2:0] m);
        @(posedge sys_clk);
        ev <= m;
        @(posedge sys_clk);
        ev <= 3'h0;
    endtask

    task automatic do_reset(input logic [2:0] m);
        @(posedge sys_clk);
        rst_n <= 1'b0;
        ev    <= m;
        @(posedge sys_clk);
        ev    <= 3'h0;
        repeat (5) @(posedge sys_clk);
        rst_n <= 1'b1;
    endtask

    // Rate pipeline is four stages deep; eight cycles leave margin
    task automatic rates(input logic [23:0] r, v, p, b);
        repeat (8) @(posedge sys_clk);
        chk("reference_clock", r, reference_clock);
        chk("vco_clock", v, vco_clock);
        chk("pll_output_clock", p, pll_output_clock);
        chk("bus_clock", b, bus_clock);
    endtask

    // ************************************************************
    // Write/read-back rows, then hand-written cases
    // ************************************************************
    row_type rows [9] = '{
        '{A_CLK, 8'h80, 8'h80, 1'b0}, '{A_MULT, 8'h05, 8'h05, 1'b0},
        '{A_REF, 8'hFF, 8'hCF, 1'b0}, '{A_POST, 8'hFF, 8'h1F, 1'b0},
        '{A_POST, 8'h01, 8'h01, 1'b0}, '{A_OSC, 8'h80, 8'h80, 1'b0},
        '{A_REF, 8'h41, 8'h41, 1'b0}, '{12'h004, 8'h55, 8'h00, 1'b1},
        '{12'h0D1, 8'h55, 8'h00, 1'b1}
    };

    initial begin
        logic [7:0] r;
        logic       e;
        do_reset(3'h1);
        foreach (rows[i]) begin
            wr(rows[i].a, rows[i].w);
            apb(1'b0, rows[i].a, 8'h00, r, e);
            chk("row data", {16'h0000, rows[i].r}, {16'h0000, r});
            chk("row error", {23'h0, rows[i].e}, {23'h0, e});
        end
        chk("pll_clock_select", 24'h1, {23'h0, pll_clock_select});
        $display("test rows done");
        // Oscillator reference, unlocked then locked
        rates(24'h000FA0, 24'h00BB80, 24'h002EE0, 24'h001770);
        chk("vco_gain_range", 24'h0, {22'h0, vco_gain_range});
        lock_detect <= 1'b1;
        rates(24'h000FA0, 24'h00BB80, 24'h005DC0, 24'h002EE0);
        n = 0;
        repeat (1000) begin
            @(posedge sys_clk);
            if (bus_clock_tick === 1'b1) n++;
        end
        if (n < 239 || n > 241) begin
            fails++;
            $display("[FAIL] bus ticks expected 240 seen %0d", n);
        end
        total_checks++;
        $display("test rates done");
        // Filter follows range field only with the oscillator on
        // 4 MHz reference sits in the second range band
        wr(A_REF, 8'h41);
        rates(24'h000FA0, 24'h00BB80, 24'h005DC0, 24'h002EE0);
        chk("filter", 24'h1, {22'h0, loop_filter_range});
        wr(A_OSC, 8'h00);
        rates(24'h0003E8, 24'h002EE0, 24'h001770, 24'h000BB8);
        chk("filter", 24'h0, {22'h0, loop_filter_range});
        wr(A_CLK, 8'h00);
        rates(24'h0003E8, 24'h002EE0, 24'h001770, 24'h0001F4);
        chk("pll_clock_select", 24'h0, {23'h0, pll_clock_select});
        $display("test filter done");
        // Flag clearing, lock clearing and refused writes
        wr(A_FLG, 8'h00);
        rd(A_FLG, 8'h78, "flags zero write");
        wr(A_FLG, 8'h10);
        rd(A_FLG, 8'h68, "flags one write");
        wr(A_CLK, 8'h80);
        wr(A_MULT, 8'h05);
        rd(A_FLG, 8'h78, "lock cleared");
        wr(A_FLG, 8'h10);
        wr(A_WRITE_PROTECT_BIT, 8'h01);
        wr(A_MULT, 8'h07);
        rd(A_MULT, 8'h05, "protected mult");
        rd(A_FLG, 8'h68, "no lock change");
        wr(A_POST, 8'h02);
        rd(A_POST, 8'h02, "post under protect");
        wr(A_WRITE_PROTECT_BIT, 8'h00);
        wr(A_CLK, 8'h00);
        wr(A_MULT, 8'h07);
        rd(A_MULT, 8'h05, "mult unselected");
        wr(A_POST, 8'h04);
        rd(A_POST, 8'h02, "post unselected");
        wr(A_REF, 8'h03);
        rd(A_REF, 8'h41, "reference_divider_field unselected");
        wr(A_OSC, 8'h80);
        osc_detect <= 1'b1;
        rd(A_FLG, 8'h6B, "osc change");
        $display("test gating done");
        // Reset causes survive a system reset
        lock_detect <= 1'b0;
        osc_detect  <= 1'b0;
        wr(A_OSC, 8'h00);
        pulse(3'h4);
        wr(A_FLG, 8'h72);
        rd(A_FLG, 8'h04, "illegal flag");
        pulse(3'h2);
        rd(A_FLG, 8'h24, "low voltage flag");
        do_reset(3'h0);
        rd(A_FLG, 8'h24, "flags kept");
        rd(A_MULT, pll_cfg_pkg::RST_MULT, "mult reset");
        rd(A_REF, pll_cfg_pkg::RST_REFERENCE_DIVIDER_FIELD, "reference_divider_field reset");
        rd(A_POST, pll_cfg_pkg::RST_POST_DIVIDER_FIELD, "post reset");
        rd(A_CLK, pll_cfg_pkg::RST_CLKSEL, "clksel reset");
        rd(A_OSC, pll_cfg_pkg::RST_OSC, "osc reset");
        rd(A_WRITE_PROTECT_BIT, pll_cfg_pkg::RST_WRITE_PROTECT_BIT, "write_protect_bit reset");
        pulse(3'h1);
        rd(A_FLG, 8'h60, "power on flags");
        $display("test reset done");
        test_done();
    end
endmodule
